/* design/csfp_id_mem.v */
`timescale 1ns/10ps
`include "csfp_map.vh"
module csfp_id_mem (
    input wire clk_i,
    input wire we_i,
    input wire [`CSFP_ID_AW-1:0] addr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o
);
    reg [7:0] mem [0:`CSFP_ID_DEPTH-1];
    // Registered read keeps the timing of the serial side simple
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule

/* design/csfp_map.vh */
`ifndef CSFP_MAP_VH
`define CSFP_MAP_VH

// Register byte offsets
`define CSFP_REG_STATUS 8'h00
`define CSFP_REG_MASK 8'h04
`define CSFP_REG_STATE 8'h08
`define CSFP_REG_LOSCNT 8'h0c

// Status and mask bit positions
`define CSFP_EV_LOS_SET 0
`define CSFP_EV_LOS_CLR 1
`define CSFP_EV_TXDIS 2
`define CSFP_EV_IDWR 3
`define CSFP_EV_W 4

// State register bit positions
`define CSFP_ST_LOS 0
`define CSFP_ST_TXDIS 1
`define CSFP_ST_IDBUSY 2

// Reset values
`define CSFP_STATUS_RST 4'h0
`define CSFP_MASK_RST 4'h0

// Loss of signal persistence
`define CSFP_LOS_UI 110
`define CSFP_LINE_RATE_KHZ 155520
`define CSFP_CLK_KHZ 25000
`define CSFP_LOS_CYC ((`CSFP_LOS_UI * `CSFP_CLK_KHZ + `CSFP_LINE_RATE_KHZ - 1) / `CSFP_LINE_RATE_KHZ)
`define CSFP_CNT_W 5

// Identification memory
`define CSFP_ID_DEV_ADDR 7'h50
`define CSFP_ID_AW 7
`define CSFP_ID_DEPTH 128

`endif

/* design/csfp_pin_ctrl.v */
`timescale 1ns/10ps
`include "csfp_map.vh"
module csfp_pin_ctrl (
    input wire clk_i,
    input wire rst_i,
    input wire tx_disable_i,
    input wire line_tx_data_p_i,
    input wire line_tx_data_n_i,
    input wire level_below_assert_i,
    input wire level_above_clear_i,
    input wire rx_recovered_i,
    input wire id_serial_clock_i,
    input wire id_serial_data_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg irq_o,
    output reg tx_line_o,
    output reg tx_line_oe_n_o,
    output reg tx_power_down_o,
    output reg rx_data_p_o,
    output reg rx_data_n_o,
    output reg rx_signal_lost_o,
    output reg id_serial_data_o,
    output reg id_serial_data_oe_n_o,
    output reg module_present_tie_o,
    output reg tx_fault_o
);
    localparam integer LOS_CYC_FULL = `CSFP_LOS_CYC;
    localparam [`CSFP_CNT_W-1:0] LOS_CYC = LOS_CYC_FULL[`CSFP_CNT_W-1:0];

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_DEV = 3'h1;
    localparam [2:0] S_DACK = 3'h2;
    localparam [2:0] S_WORD = 3'h3;
    localparam [2:0] S_WACK = 3'h4;
    localparam [2:0] S_WDAT = 3'h5;
    localparam [2:0] S_RDAT = 3'h6;
    localparam [2:0] S_RACK = 3'h7;

    wire [6:0] pin_sync;
    wire txdis_s;
    wire txp_s;
    wire below_s;
    wire above_s;
    wire rxd_s;
    wire scl_s;
    wire sda_s;

    csfp_sync #(
        .WIDTH(7),
        .RST_VAL(7'h61)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({id_serial_data_i, id_serial_clock_i, rx_recovered_i,
            level_above_clear_i, level_below_assert_i, line_tx_data_p_i, tx_disable_i}),
        .sync_o(pin_sync)
    );
    assign txdis_s = pin_sync[0];
    assign txp_s = pin_sync[1];
    assign below_s = pin_sync[2];
    assign above_s = pin_sync[3];
    assign rxd_s = pin_sync[4];
    assign scl_s = pin_sync[5];
    assign sda_s = pin_sync[6];

    // Transmit path; the inverted input carries no extra information
    wire unused_txn;
    assign unused_txn = line_tx_data_n_i;

    reg txdis_d;
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_power_down_o <= 1'b1;
            tx_line_oe_n_o <= 1'b1;
            tx_line_o <= 1'b0;
            txdis_d <= 1'b1;
        end else begin
            txdis_d <= txdis_s;
            tx_power_down_o <= txdis_s;
            tx_line_oe_n_o <= txdis_s;
            tx_line_o <= txdis_s ? 1'b0 : txp_s;
        end
    end

    // Loss of signal detector with hysteresis
    reg [`CSFP_CNT_W-1:0] los_cnt;
    reg los;
    always @(posedge clk_i) begin
        if (rst_i) begin
            los <= 1'b1;
            los_cnt <= {`CSFP_CNT_W{1'b0}};
        end else if (!los) begin
            if (!below_s) begin
                los_cnt <= {`CSFP_CNT_W{1'b0}};
            end else if (los_cnt == LOS_CYC - 1'b1) begin
                los <= 1'b1;
                los_cnt <= {`CSFP_CNT_W{1'b0}};
            end else begin
                los_cnt <= los_cnt + 1'b1;
            end
        end else begin
            if (!above_s) begin
                los_cnt <= {`CSFP_CNT_W{1'b0}};
            end else if (los_cnt == LOS_CYC - 1'b1) begin
                los <= 1'b0;
                los_cnt <= {`CSFP_CNT_W{1'b0}};
            end else begin
                los_cnt <= los_cnt + 1'b1;
            end
        end
    end

    // Receive path and fixed pins
    reg los_d;
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_data_p_o <= 1'b0;
            rx_data_n_o <= 1'b0;
            rx_signal_lost_o <= 1'b1;
            los_d <= 1'b1;
            module_present_tie_o <= 1'b0;
            tx_fault_o <= 1'b0;
        end else begin
            los_d <= los;
            rx_signal_lost_o <= los;
            // Both legs flat while squelched, so no false edges reach the host
            rx_data_p_o <= los ? 1'b0 : rxd_s;
            rx_data_n_o <= los ? 1'b0 : ~rxd_s;
            module_present_tie_o <= 1'b0;
            tx_fault_o <= 1'b0;
            // Rate select has no port at all, so no level on it reaches logic
        end
    end

    // Two-wire identification slave
    reg scl_d;
    reg sda_d;
    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx_shift;
    reg [7:0] tx_shift;
    reg rd_mode;
    reg host_nack;
    reg [`CSFP_ID_AW-1:0] word_addr;
    reg mem_we;
    reg word_addr_step;
    reg [7:0] mem_wdata;
    wire [7:0] mem_rdata;

    csfp_id_mem u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .addr_i(word_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            rd_mode <= 1'b0;
            host_nack <= 1'b0;
            word_addr <= {`CSFP_ID_AW{1'b0}};
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
            id_serial_data_o <= 1'b0;
            id_serial_data_oe_n_o <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            mem_we <= 1'b0;
            id_serial_data_o <= 1'b0;
            if (bus_start) begin
                state <= S_DEV;
                bit_cnt <= 4'h0;
                id_serial_data_oe_n_o <= 1'b1;
            end else if (bus_stop) begin
                state <= S_IDLE;
                id_serial_data_oe_n_o <= 1'b1;
            end else if (scl_rise) begin
                // Data is taken only on the rising clock edge
                if (state == S_RACK) begin
                    host_nack <= sda_s;
                end else if (state != S_IDLE) begin
                    rx_shift <= {rx_shift[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                // Data driven only after the falling edge
                case (state)
                    S_DEV: begin
                        if (bit_cnt == 4'h8) begin
                            if (rx_shift[7:1] == `CSFP_ID_DEV_ADDR) begin
                                rd_mode <= rx_shift[0];
                                id_serial_data_oe_n_o <= 1'b0;
                                state <= S_DACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_DACK: begin
                        bit_cnt <= 4'h0;
                        if (rd_mode) begin
                            tx_shift <= mem_rdata;
                            id_serial_data_oe_n_o <= mem_rdata[7];
                            state <= S_RDAT;
                        end else begin
                            id_serial_data_oe_n_o <= 1'b1;
                            state <= S_WORD;
                        end
                    end
                    S_WORD: begin
                        if (bit_cnt == 4'h8) begin
                            word_addr <= rx_shift[`CSFP_ID_AW-1:0];
                            id_serial_data_oe_n_o <= 1'b0;
                            state <= S_WACK;
                        end
                    end
                    S_WDAT: begin
                        if (bit_cnt == 4'h8) begin
                            mem_we <= 1'b1;
                            mem_wdata <= rx_shift;
                            id_serial_data_oe_n_o <= 1'b0;
                            state <= S_WACK;
                        end
                    end
                    S_WACK: begin
                        // Address advances after a stored byte, not after the word address
                        if (word_addr_step) begin
                            word_addr <= word_addr + 1'b1;
                        end
                        bit_cnt <= 4'h0;
                        id_serial_data_oe_n_o <= 1'b1;
                        state <= S_WDAT;
                    end
                    S_RDAT: begin
                        if (bit_cnt == 4'h8) begin
                            id_serial_data_oe_n_o <= 1'b1;
                            word_addr <= word_addr + 1'b1;
                            state <= S_RACK;
                        end else begin
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            id_serial_data_oe_n_o <= tx_shift[6];
                        end
                    end
                    S_RACK: begin
                        bit_cnt <= 4'h0;
                        if (host_nack) begin
                            state <= S_IDLE;
                        end else begin
                            tx_shift <= mem_rdata;
                            id_serial_data_oe_n_o <= mem_rdata[7];
                            state <= S_RDAT;
                        end
                    end
                    default: begin
                        id_serial_data_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Marks that the last acknowledge followed a stored data byte
    always @(posedge clk_i) begin
        if (rst_i) begin
            word_addr_step <= 1'b0;
        end else if (mem_we) begin
            word_addr_step <= 1'b1;
        end else if (scl_fall && state == S_WACK) begin
            word_addr_step <= 1'b0;
        end
    end

    // Events, interrupt and Wishbone slave
    wire [`CSFP_EV_W-1:0] ev_set;
    assign ev_set = {mem_we, txdis_s ^ txdis_d, los_d & ~los, los & ~los_d};

    reg [`CSFP_EV_W-1:0] status;
    reg [`CSFP_EV_W-1:0] mask;
    reg [`CSFP_EV_W-1:0] next_status;
    wire wb_req;
    wire wb_wr;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

    always @* begin
        next_status = status;
        if (wb_wr && wb_adr_i == `CSFP_REG_STATUS) begin
            next_status = status & ~wb_dat_i[`CSFP_EV_W-1:0];
        end
        // An event in the clearing cycle survives
        next_status = next_status | ev_set;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            status <= `CSFP_STATUS_RST;
            mask <= `CSFP_MASK_RST;
            irq_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            status <= next_status;
            irq_o <= |(next_status & mask);
            wb_ack_o <= wb_req;
            if (wb_wr && wb_adr_i == `CSFP_REG_MASK) begin
                mask <= wb_dat_i[`CSFP_EV_W-1:0];
            end
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `CSFP_REG_STATUS: wb_dat_o <= {28'h0000000, status};
                    `CSFP_REG_MASK: wb_dat_o <= {28'h0000000, mask};
                    `CSFP_REG_STATE: wb_dat_o <= {29'h00000000, state != S_IDLE,
                        txdis_s, los};
                    `CSFP_REG_LOSCNT: wb_dat_o <= {27'h0000000, los_cnt};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* design/csfp_sync.v */
`timescale 1ns/10ps
module csfp_sync #(
    parameter WIDTH = 1,
    // Idle level of each pin, so no false edge follows reset
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
            // First stage feeds only the second
            always @(posedge clk_i) begin
                if (rst_i) begin
                    stage1[g] <= RST_VAL[g];
                    stage2[g] <= RST_VAL[g];
                end else begin
                    stage1[g] <= async_i[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate
    assign sync_o = stage2;
endmodule

/* verif/csfp_host_model.sv */
`timescale 1ns/10ps
module csfp_host_model (
    input wire clk_i,
    input wire oe_n_i,
    output reg scl_o,
    output wire sda_o
);
    reg host_rel;
    // Pull-up wire: low if either party pulls
    assign sda_o = host_rel & oe_n_i;
    initial begin
        scl_o = 1'b1;
        host_rel = 1'b1;
    end
    task hp;
        begin
            repeat (12) @(posedge clk_i);
        end
    endtask
    // Data moves only while clock is low, away from the falling edge
    task bit_io(input b, output r);
        begin
            repeat (2) @(posedge clk_i);
            host_rel <= b;
            hp;
            scl_o <= 1'b1;
            hp;
            r = sda_o;
            scl_o <= 1'b0;
        end
    endtask
    task id_start;
        begin
            @(posedge clk_i);
            host_rel <= 1'b1;
            hp;
            scl_o <= 1'b1;
            hp;
            host_rel <= 1'b0;
            hp;
            scl_o <= 1'b0;
        end
    endtask
    task id_stop;
        begin
            repeat (2) @(posedge clk_i);
            host_rel <= 1'b0;
            hp;
            scl_o <= 1'b1;
            hp;
            host_rel <= 1'b1;
            hp;
        end
    endtask
    // Byte out, most significant first, then the acknowledge slot
    task id_xfer(input [7:0] tx, input ab, output [7:0] rx, output ak);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(tx[i], r);
                rx[i] = r;
            end
            bit_io(ab, ak);
        end
    endtask
endmodule

/* verif/csfp_pin_ctrl_monitor.sv */
`timescale 1ns/10ps
module csfp_pin_ctrl_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire tx_disable_i,
    input wire level_below_assert_i,
    input wire level_above_clear_i,
    input wire id_serial_clock_i,
    input wire tx_line_o,
    input wire tx_line_oe_n_o,
    input wire tx_power_down_o,
    input wire rx_data_p_o,
    input wire rx_data_n_o,
    input wire rx_signal_lost_o,
    input wire id_serial_data_o,
    input wire id_serial_data_oe_n_o,
    input wire module_present_tie_o,
    input wire tx_fault_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_tx_goes_off: assert property (tx_disable_i [*3] |=>
        tx_power_down_o && tx_line_oe_n_o)
        else $error("transmitter not off");
    a_tx_goes_on: assert property (!tx_disable_i [*4] |=>
        !tx_power_down_o && !tx_line_oe_n_o)
        else $error("transmitter not on");
    a_tx_quiet: assert property (tx_line_oe_n_o |-> !tx_line_o && tx_power_down_o)
        else $error("line driven while off");
    a_lost_persist: assert property ($rose(rx_signal_lost_o) |->
        $past(level_below_assert_i, 4) && $past(level_below_assert_i, 18))
        else $error("signal lost too early");
    a_clear_persist: assert property ($fell(rx_signal_lost_o) |->
        $past(level_above_clear_i, 4) && $past(level_above_clear_i, 18))
        else $error("signal lost cleared too early");
    a_rx_squelch: assert property (rx_signal_lost_o |->
        !rx_data_p_o && !rx_data_n_o)
        else $error("data not squelched");
    a_nrz_pair: assert property (!rx_signal_lost_o |-> rx_data_p_o != rx_data_n_o)
        else $error("outputs not a true pair");
    a_id_pull_low: assert property (!id_serial_data_oe_n_o |-> !id_serial_data_o)
        else $error("id data driven high");
    a_id_change_low: assert property ($changed(id_serial_data_oe_n_o) |->
        !id_serial_clock_i)
        else $error("id data changed while clock high");
    a_pins_grounded: assert property (
        !module_present_tie_o && !tx_fault_o)
        else $error("tie pin not low");
endmodule
bind csfp_pin_ctrl csfp_pin_ctrl_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .tx_disable_i(tx_disable_i), .level_below_assert_i(level_below_assert_i),
    .level_above_clear_i(level_above_clear_i), .id_serial_clock_i(id_serial_clock_i),
    .tx_line_o(tx_line_o), .tx_line_oe_n_o(tx_line_oe_n_o),
    .tx_power_down_o(tx_power_down_o), .rx_data_p_o(rx_data_p_o),
    .rx_data_n_o(rx_data_n_o), .rx_signal_lost_o(rx_signal_lost_o),
    .id_serial_data_o(id_serial_data_o), .id_serial_data_oe_n_o(id_serial_data_oe_n_o),
    .module_present_tie_o(module_present_tie_o), .tx_fault_o(tx_fault_o));

/* verif/csfp_pin_ctrl_tb.sv */
`timescale 1ns/10ps
`include "csfp_map.vh"
module csfp_pin_ctrl_tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg tx_dis = 1'b1;
    reg tdp = 1'b0;
    reg below = 1'b0;
    reg above = 1'b1;
    reg rxd = 1'b0;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire ack, irq, txl, txoe_n, txpd, rxp, rxn, lost, sdo, sdoe_n, pres, fault, scl, sda;
    integer bad_count = 0;
    integer compares = 0;
    integer st = 2;
    integer i;
    reg [31:0] rd;
    reg [7:0] b, wa;
    reg [7:0] idm [0:1];
    reg a;
    always #20 clk_i = ~clk_i;
    csfp_pin_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .tx_disable_i(tx_dis),
        .line_tx_data_p_i(tdp), .line_tx_data_n_i(!tdp), .level_below_assert_i(below),
        .level_above_clear_i(above), .rx_recovered_i(rxd), .id_serial_clock_i(scl),
        .id_serial_data_i(sda), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .tx_line_o(txl), .tx_line_oe_n_o(txoe_n), .tx_power_down_o(txpd),
        .rx_data_p_o(rxp), .rx_data_n_o(rxn), .rx_signal_lost_o(lost),
        .id_serial_data_o(sdo), .id_serial_data_oe_n_o(sdoe_n),
        .module_present_tie_o(pres), .tx_fault_o(fault));
    csfp_host_model host (.clk_i(clk_i), .oe_n_i(sdoe_n), .scl_o(scl), .sda_o(sda));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task wb(input w, input [7:0] ad, input [31:0] dt);
        begin
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= ad;
            wdat <= dt;
            @(posedge clk_i);
            while (ack !== 1'b1) begin
                @(posedge clk_i);
            end
            rd = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task finish_test;
        begin
            $display("compares %0d mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        #1600000;
        bad_count = bad_count + 1;
        finish_test;
    end
    initial begin
        i = $urandom(78);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({txpd, txoe_n, txl, lost, rxp, rxn, sdoe_n, irq, ack, pres, fault}, 11'h690);
        repeat (30) @(posedge clk_i);
        check(lost, 1'b0);
        for (i = 0; i < 12; i = i + 1) begin
            b = $urandom;
            if (b[0] !== tx_dis)
                st = st | 4;
            tx_dis <= b[0];
            tdp <= b[1];
            rxd <= b[2];
            repeat (4) @(posedge clk_i);
            check({txpd, txoe_n, txl}, {tx_dis, tx_dis, tdp & !tx_dis});
            check({rxp, rxn}, {rxd, !rxd});
        end
        $display("test tx and rx data done");
        // Hold just short of the count twice, so only a missed restart trips it
        rxd <= 1'b1;
        below <= 1'b1;
        above <= 1'b0;
        repeat (15) @(posedge clk_i);
        below <= 1'b0;
        repeat (2) @(posedge clk_i);
        below <= 1'b1;
        repeat (15) @(posedge clk_i);
        check(lost, 1'b0);
        repeat (10) @(posedge clk_i);
        check({lost, rxp, rxn}, 3'b100);
        st = st | 1;
        below <= 1'b0;
        above <= 1'b1;
        repeat (25) @(posedge clk_i);
        check(lost, 1'b0);
        $display("test signal lost done");
        wb(1'b0, `CSFP_REG_MASK, 0);
        check(rd, 0);
        check(irq, 1'b0);
        wb(1'b0, `CSFP_REG_LOSCNT, 0);
        check(rd, 0);
        wa = $urandom & 8'h7f;
        idm[0] = $urandom;
        idm[1] = $urandom;
        host.id_start;
        host.id_xfer(8'ha0, 1'b1, b, a);
        check(a, 1'b0);
        host.id_xfer(wa, 1'b1, b, a);
        host.id_xfer(idm[0], 1'b1, b, a);
        host.id_xfer(idm[1], 1'b1, b, a);
        check(a, 1'b0);
        host.id_stop;
        st = st | 8;
        host.id_start;
        host.id_xfer(8'ha0, 1'b1, b, a);
        host.id_xfer(wa, 1'b1, b, a);
        host.id_start;
        host.id_xfer(8'ha1, 1'b1, b, a);
        host.id_xfer(8'hff, 1'b0, b, a);
        check(b, idm[0]);
        host.id_xfer(8'hff, 1'b1, b, a);
        check(b, idm[1]);
        host.id_stop;
        host.id_start;
        host.id_xfer(8'ha2, 1'b1, b, a);
        check(a, 1'b1);
        host.id_stop;
        $display("test id link done");
        wb(1'b0, `CSFP_REG_STATUS, 0);
        check(rd, st);
        wb(1'b0, `CSFP_REG_STATE, 0);
        check(rd[2:0], {1'b0, tx_dis, 1'b0});
        wb(1'b1, `CSFP_REG_MASK, 32'hf);
        @(posedge clk_i);
        check(irq, 1'b1);
        wb(1'b1, `CSFP_REG_STATUS, 32'hf);
        @(posedge clk_i);
        check(irq, 1'b0);
        wb(1'b0, `CSFP_REG_STATUS, 0);
        check(rd, 0);
        wb(1'b0, 8'h10, 0);
        check(rd, 0);
        $display("test registers done");
        finish_test;
    end
endmodule
